// ===== rtl/gesb_pkg.sv
/*
 * Constants and carrier types for the general event and status block.
 * Assumes one 100 MHz clock and byte-wide configuration-space accesses.
 */
// Contract
// - Loader status bits 2..0 are reached only through configuration function zero.
// - Loader status bits 7..3 always read zero.
// - EEPROM present bit shows whether the loader found an EEPROM.
// - Missing acknowledge during EEPROM transfer sets the error flag.
// - Writing 1 clears the error flag; writing 0 leaves it.
// - Loading bit reads 1 while subsystem identification is fetched.
// - Flag bit 7 sets when software alters either socket power state.
// - Flag bit 6 sets when requested programming voltage goes to/from 12 V.
// - Flag bit n sets on level change of pin n while it is input n.
// - Bits 5 and 4 of flags and enables always read zero.
// - Enable bit 7 with power flag set asserts the event output.
// - Enable bit 6 with voltage flag set asserts the event output.
// - Enable bit n with input-change flag n set asserts the event output.
// - Input register bits 3..0 show present sampled input levels.
// - Input register bits 7..4 always read zero.
// - Event output reaches pin 5 only when its routing code is 101.
// - Pin n acts as general input only when its routing code is 000; the code gates only its change flag, its level always reads.
package gesb_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_LOADER_STATUS = 8'h85;
	localparam logic [7:0] OFS_EVENT_FLAGS   = 8'h88;
	localparam logic [7:0] OFS_EVENT_ENABLES = 8'h89;
	localparam logic [7:0] OFS_INPUT_LEVELS  = 8'h8a;

	// ----------------------------------------
	// Field positions and masks
	// ----------------------------------------
	localparam int         BIT_LOADING      = 0;
	localparam int         BIT_ACK_ERROR    = 1;
	localparam int         BIT_PRESENT      = 2;
	localparam int         BIT_HV_REQUEST   = 6;
	localparam int         BIT_POWER_CHANGE = 7;
	localparam int         NUM_INPUTS       = 4;
	localparam logic [7:0] EVENT_MASK       = 8'hcf;
	localparam logic [7:0] INPUT_MASK       = 8'h0f;
	localparam logic [7:0] RESET_BYTE       = 8'h00;
	localparam logic [2:0] FUNC_ZERO        = 3'h0;

	// ----------------------------------------
	// Pin routing codes
	// ----------------------------------------
	localparam logic [2:0] ROUTE_GEN_INPUT  = 3'h0;
	localparam logic [2:0] ROUTE_GEN_EVENT  = 3'h5;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [2:0] func;
		logic [7:0] addr;
		logic [7:0] wdata;
	} gesb_cfg_req_type;

	typedef struct packed {
		logic       ack_missing;
		logic       loading;
		logic       present;
	} gesb_loader_type;

	typedef struct packed {
		logic       power_change;
		logic       hv_request_change;
	} gesb_socket_evt_type;

endpackage

// ===== rtl/gesb_input_sync.sv
/*
 * Two-stage synchroniser and level-change detector, one lane per input.
 * Assumes inputs are asynchronous pins; reset held at least three edges.
 */
`timescale 1ns/1ps
`default_nettype none
module gesb_input_sync
	import gesb_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  srst_i,
	// Pins in, levels and changes out
	input  wire logic [NUM_INPUTS-1:0] pin_i,
	output logic      [NUM_INPUTS-1:0] level_o,
	output logic      [NUM_INPUTS-1:0] change_o
);

	genvar g;
	generate
		for (g = 0; g < NUM_INPUTS; g++) begin : lane
			logic meta_q;
			logic sync_q;
			logic prev_q;
			logic prev_d;

			// Prev tracks sync in reset so release gives no false change
			always_comb begin
				prev_d = sync_q;
			end

			always_ff @(posedge clk_i) begin
				meta_q <= pin_i[g];
				sync_q <= meta_q;
				prev_q <= prev_d;
			end

			assign level_o[g]  = sync_q;
			assign change_o[g] = !srst_i && (sync_q != prev_q);
		end
	endgenerate

endmodule
`default_nettype wire

// ===== rtl/gesb_flag_bank.sv
/*
 * Bank of sticky event flags cleared by writing one.
 * Assumes set and clear strobes come from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module gesb_flag_bank
	import gesb_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	// Strobes
	input  wire logic [7:0] set_i,
	input  wire logic [7:0] clr_i,
	input  wire logic [7:0] keep_i,
	// Flags
	output logic      [7:0] flags_o
);

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : bit_cell
			logic flag_q;
			logic flag_d;

			always_comb begin
				if (!keep_i[g]) begin
					flag_d = 1'b0;
				end else if (set_i[g]) begin
					flag_d = 1'b1;
				end else if (clr_i[g]) begin
					flag_d = 1'b0;
				end else begin
					flag_d = flag_q;
				end
			end

			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					flag_q <= RESET_BYTE[g];
				end else begin
					flag_q <= flag_d;
				end
			end

			assign flags_o[g] = flag_q;
		end
	endgenerate

endmodule
`default_nettype wire

// ===== rtl/gesb_top.sv
/*
 * General event and status register group: loader status, sticky
 * event flags with enables, live input levels and the event output.
 * Assumes byte configuration accesses on CLK_I, loader and socket
 * strobes on CLK_I, pins asynchronous, routing fields from elsewhere.
 */
`timescale 1ns/1ps
`default_nettype none
module gesb_top
	import gesb_pkg::*;
(
	// Clock and reset
	input  wire logic                  CLK_I,
	input  wire logic                  SRST_I,
	// Configuration access
	input  wire gesb_cfg_req_type      CFG_REQ_I,
	output logic      [7:0]            CFG_RDATA_O,
	output logic                       CFG_RVALID_O,
	// Loader and socket events
	input  wire gesb_loader_type       LOADER_I,
	input  wire gesb_socket_evt_type   SOCKET_EVT_I,
	// Multipurpose pins and routing
	input  wire logic [NUM_INPUTS-1:0] MULTIPURPOSE_PIN_I,
	input  wire logic [3*NUM_INPUTS-1:0] PIN_ROUTE_I,
	input  wire logic [2:0]            PIN5_ROUTE_I,
	output logic                       MULTIPURPOSE_PIN5_O,
	output logic                       MULTIPURPOSE_PIN5_OE_O,
	// Event output
	output logic                       GENERAL_EVENT_OUT_N_O
);

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	logic func_zero;
	logic wr_status;
	logic wr_flags;
	logic wr_enables;

	assign func_zero  = (CFG_REQ_I.func == FUNC_ZERO);
	assign wr_status  = CFG_REQ_I.wr && func_zero &&
	                    (CFG_REQ_I.addr == OFS_LOADER_STATUS);
	assign wr_flags   = CFG_REQ_I.wr && (CFG_REQ_I.addr == OFS_EVENT_FLAGS);
	assign wr_enables = CFG_REQ_I.wr && (CFG_REQ_I.addr == OFS_EVENT_ENABLES);

	// ----------------------------------------
	// Input pins
	// ----------------------------------------
	logic [NUM_INPUTS-1:0] input_level;
	logic [NUM_INPUTS-1:0] input_change;
	logic [NUM_INPUTS-1:0] input_routed;
	logic [NUM_INPUTS-1:0] routed_change;

	// Routing is judged at detection; a later code change cannot revive an edge
	gesb_input_sync gesb_input_sync_inst (
		.clk_i    (CLK_I),
		.srst_i   (SRST_I),
		.pin_i    (MULTIPURPOSE_PIN_I),
		.level_o  (input_level),
		.change_o (input_change)
	);

	genvar g;
	generate
		for (g = 0; g < NUM_INPUTS; g++) begin : route
			assign input_routed[g] = (PIN_ROUTE_I[3*g +: 3] == ROUTE_GEN_INPUT);
		end
	endgenerate

	assign routed_change = input_change & input_routed;

	// ----------------------------------------
	// Loader status
	// ----------------------------------------
	logic present_q;
	logic present_d;
	logic loading_q;
	logic loading_d;
	logic ack_err_q;
	logic ack_err_d;

	// Present and loading lag the loader by one edge
	always_comb begin
		present_d = LOADER_I.present;
		loading_d = LOADER_I.loading;
		if (LOADER_I.ack_missing) begin
			ack_err_d = 1'b1;
		end else if (wr_status && CFG_REQ_I.wdata[BIT_ACK_ERROR]) begin
			ack_err_d = 1'b0;
		end else begin
			ack_err_d = ack_err_q;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			present_q <= 1'b0;
			loading_q <= 1'b0;
			ack_err_q <= 1'b0;
		end else begin
			present_q <= present_d;
			loading_q <= loading_d;
			ack_err_q <= ack_err_d;
		end
	end

	// ----------------------------------------
	// Event flags
	// ----------------------------------------
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	logic [7:0] flags;

	always_comb begin
		flag_set = RESET_BYTE;
		flag_set[BIT_POWER_CHANGE] = SOCKET_EVT_I.power_change;
		flag_set[BIT_HV_REQUEST]   = SOCKET_EVT_I.hv_request_change;
		flag_set[NUM_INPUTS-1:0]   = routed_change;
		flag_clr = wr_flags ? CFG_REQ_I.wdata : RESET_BYTE;
	end

	// reserved bits held clear
	// Set and clear in one edge: the bank lets the set win
	gesb_flag_bank gesb_flag_bank_inst (
		.clk_i   (CLK_I),
		.srst_i  (SRST_I),
		.set_i   (flag_set),
		.clr_i   (flag_clr),
		.keep_i  (EVENT_MASK),
		.flags_o (flags)
	);

	// ----------------------------------------
	// Event enables
	// ----------------------------------------
	logic [7:0] enables_q;
	logic [7:0] enables_d;

	always_comb begin
		if (wr_enables) begin
			// reserved enables stay zero
			// Masked on entry so the read path needs no mask
			enables_d = CFG_REQ_I.wdata & EVENT_MASK;
		end else begin
			enables_d = enables_q;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			enables_q <= RESET_BYTE;
		end else begin
			enables_q <= enables_d;
		end
	end

	// ----------------------------------------
	// Event sources
	// ----------------------------------------
	logic                  power_hit;
	logic                  hv_hit;
	logic [NUM_INPUTS-1:0] input_hit;
	logic                  any_hit;

	// Reserved bits 5..4 never join the output term
	always_comb begin
		power_hit = flags[BIT_POWER_CHANGE] & enables_q[BIT_POWER_CHANGE];
		hv_hit    = flags[BIT_HV_REQUEST] & enables_q[BIT_HV_REQUEST];
		input_hit = flags[NUM_INPUTS-1:0] & enables_q[NUM_INPUTS-1:0];
		any_hit   = power_hit | hv_hit | (|input_hit);
	end

	// ----------------------------------------
	// Event output
	// ----------------------------------------
	logic event_n_q;
	logic event_n_d;

	always_comb begin
		event_n_d = ~any_hit;
	end

	// Output is a flop so pin glitches cannot come from the AND tree
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			event_n_q <= 1'b1;
		end else begin
			event_n_q <= event_n_d;
		end
	end

	assign GENERAL_EVENT_OUT_N_O = event_n_q;

	// ----------------------------------------
	// Pin 5 drive
	// ----------------------------------------
	logic pin5_q;
	logic pin5_d;
	logic pin5_oe_q;
	logic pin5_oe_d;

	always_comb begin
		pin5_d    = event_n_d;
		pin5_oe_d = (PIN5_ROUTE_I == ROUTE_GEN_EVENT);
	end

	// Pin released in reset so nothing is driven before routing is known
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			pin5_q    <= 1'b1;
			pin5_oe_q <= 1'b0;
		end else begin
			pin5_q    <= pin5_d;
			pin5_oe_q <= pin5_oe_d;
		end
	end

	assign MULTIPURPOSE_PIN5_O    = pin5_q;
	assign MULTIPURPOSE_PIN5_OE_O = pin5_oe_q;

	// ----------------------------------------
	// Read bytes
	// ----------------------------------------
	logic [7:0] status_byte;
	logic [7:0] flags_byte;
	logic [7:0] levels_byte;

	always_comb begin
		status_byte                = RESET_BYTE;
		status_byte[BIT_PRESENT]   = present_q;
		status_byte[BIT_ACK_ERROR] = ack_err_q;
		status_byte[BIT_LOADING]   = loading_q;
		flags_byte                 = flags & EVENT_MASK;
		levels_byte                = {{(8-NUM_INPUTS){1'b0}}, input_level} & INPUT_MASK;
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       rvalid_q;
	logic       rvalid_d;

	// Every read answers, mapped or not, so the host never waits
	always_comb begin
		rdata_d  = RESET_BYTE;
		rvalid_d = CFG_REQ_I.rd;
		if (CFG_REQ_I.rd) begin
			unique case (CFG_REQ_I.addr)
				OFS_LOADER_STATUS: begin
					rdata_d = func_zero ? status_byte : RESET_BYTE;
				end
				OFS_EVENT_FLAGS: begin
					rdata_d = flags_byte;
				end
				OFS_EVENT_ENABLES: begin
					rdata_d = enables_q;
				end
				OFS_INPUT_LEVELS: begin
					rdata_d = levels_byte;
				end
				default: begin
					rdata_d = RESET_BYTE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			rdata_q  <= RESET_BYTE;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign CFG_RDATA_O  = rdata_q;
	assign CFG_RVALID_O = rvalid_q;

endmodule
`default_nettype wire

// ===== test/gesb_chk.sv
/*
 * Port checker for the general event and status block.
 * Assumes it is bound onto gesb_top: one clock, synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module gesb_chk
	import gesb_pkg::*;
(
	// Clock and reset
	input wire logic                CLK_I,
	input wire logic                SRST_I,
	// Watched ports
	input wire gesb_cfg_req_type    CFG_REQ_I,
	input wire logic [7:0]          CFG_RDATA_O,
	input wire logic                CFG_RVALID_O,
	input wire gesb_loader_type     LOADER_I,
	input wire gesb_socket_evt_type SOCKET_EVT_I,
	input wire logic [2:0]          PIN5_ROUTE_I,
	input wire logic                MULTIPURPOSE_PIN5_O,
	input wire logic                MULTIPURPOSE_PIN5_OE_O,
	input wire logic                GENERAL_EVENT_OUT_N_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SRST_I);

	sequence s_rd(logic [7:0] a);
		CFG_REQ_I.rd && CFG_REQ_I.addr == a;
	endsequence
	// Two write-free edges with the output already low
	sequence s_quiet;
		!CFG_REQ_I.wr ##1 !CFG_REQ_I.wr && !GENERAL_EVENT_OUT_N_O;
	endsequence

	func_zero_a: assert property (s_rd(OFS_LOADER_STATUS) ##0 CFG_REQ_I.func != FUNC_ZERO
		|=> CFG_RVALID_O && CFG_RDATA_O == 8'h00) else $error("Status seen from other function");
	stat_rsvd_a: assert property (s_rd(OFS_LOADER_STATUS)
		|=> CFG_RVALID_O && CFG_RDATA_O[7:3] == 5'h00) else $error("Status high bits set");
	ack_err_a: assert property (LOADER_I.ack_missing ##1 s_rd(OFS_LOADER_STATUS)
		##0 CFG_REQ_I.func == FUNC_ZERO |=> CFG_RDATA_O[1]) else $error("Ack error not set");
	power_flag_a: assert property (SOCKET_EVT_I.power_change ##1 s_rd(OFS_EVENT_FLAGS)
		|=> CFG_RDATA_O[7]) else $error("Power flag not set");
	hv_flag_a: assert property (SOCKET_EVT_I.hv_request_change ##1 s_rd(OFS_EVENT_FLAGS)
		|=> CFG_RDATA_O[6]) else $error("Voltage flag not set");
	evt_rsvd_a: assert property (CFG_REQ_I.rd && CFG_REQ_I.addr[7:1] == 7'h44
		|=> CFG_RDATA_O[5:4] == 2'h0) else $error("Event bits 5..4 set");
	in_rsvd_a: assert property (s_rd(OFS_INPUT_LEVELS)
		|=> CFG_RDATA_O[7:4] == 4'h0) else $error("Input high bits set");
	pin5_oe_a: assert property (!$past(SRST_I)
		|-> MULTIPURPOSE_PIN5_OE_O == $past(PIN5_ROUTE_I == ROUTE_GEN_EVENT))
		else $error("Pin 5 enable wrong");
	pin5_val_a: assert property (MULTIPURPOSE_PIN5_O == GENERAL_EVENT_OUT_N_O)
		else $error("Pin 5 differs from event output");
	gpe_hold_a: assert property (s_quiet |=> !GENERAL_EVENT_OUT_N_O)
		else $error("Event output released without write");
endmodule

bind gesb_top gesb_chk gesb_chk_inst (.CLK_I(CLK_I), .SRST_I(SRST_I), .CFG_REQ_I(CFG_REQ_I),
	.CFG_RDATA_O(CFG_RDATA_O), .CFG_RVALID_O(CFG_RVALID_O), .LOADER_I(LOADER_I),
	.SOCKET_EVT_I(SOCKET_EVT_I), .PIN5_ROUTE_I(PIN5_ROUTE_I),
	.MULTIPURPOSE_PIN5_O(MULTIPURPOSE_PIN5_O), .MULTIPURPOSE_PIN5_OE_O(MULTIPURPOSE_PIN5_OE_O),
	.GENERAL_EVENT_OUT_N_O(GENERAL_EVENT_OUT_N_O));
`default_nettype wire

// ===== test/tb_top.sv
/*
 * Self-checking bench for gesb_top: reads queue expectations,
 * a monitor compares them as read data returns.
 * Assumes the package and checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import gesb_pkg::*;
	logic                clk_i    = 1'b0;
	logic                srst_i   = 1'b1;
	gesb_cfg_req_type    req      = '0;
	gesb_loader_type     ldr      = '0;
	gesb_socket_evt_type sock     = '0;
	logic [3:0]          pins     = 4'h0;
	logic [11:0]         route    = 12'h000;
	logic [2:0]          route5   = 3'h0;
	logic [7:0]          rdata;
	logic                rvalid;
	logic                pin5;
	logic                pin5_oe;
	logic                gpe_n;
	logic [7:0]          v;
	logic [7:0]          expq[$];
	int                  n_errors = 0;
	int                  checks_done = 0;
	int                  seed     = 6229;
	int                  i;

	always #5 clk_i = ~clk_i;

	gesb_top gesb_top_inst (.CLK_I(clk_i), .SRST_I(srst_i), .CFG_REQ_I(req),
		.CFG_RDATA_O(rdata), .CFG_RVALID_O(rvalid), .LOADER_I(ldr), .SOCKET_EVT_I(sock),
		.MULTIPURPOSE_PIN_I(pins), .PIN_ROUTE_I(route), .PIN5_ROUTE_I(route5),
		.MULTIPURPOSE_PIN5_O(pin5), .MULTIPURPOSE_PIN5_OE_O(pin5_oe),
		.GENERAL_EVENT_OUT_N_O(gpe_n));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One request cycle; requests are left standing for back-to-back use
	task automatic acc(input logic r, w, input logic [2:0] f, input logic [7:0] a, d, e);
		req = '{r, w, f, a, d};
		if (r)
			expq.push_back(e);
		@(posedge clk_i);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, e);
		acc(1'b1, 1'b0, FUNC_ZERO, a, 8'h00, e);
	endtask
	task automatic wr(input logic [7:0] a, d);
		acc(1'b0, 1'b1, FUNC_ZERO, a, d, 8'h00);
	endtask
	task automatic idle(input int n);
		repeat (n) acc(1'b0, 1'b0, FUNC_ZERO, 8'h00, 8'h00, 8'h00);
	endtask
	task automatic gpe_wait(input logic lvl);
		repeat (10) if (gpe_n !== lvl) idle(1);
		chk({7'h00, gpe_n}, {7'h00, lvl});
		if (gpe_n !== lvl)
			results();
	endtask

	// Read data monitor; an unasked answer meets a bogus expectation
	always @(posedge clk_i)
		if (!srst_i && rvalid !== 1'b0)
			chk(rdata, (expq.size() > 0) ? expq.pop_front() : 8'hee);

	initial begin
		repeat (5) @(posedge clk_i);
		#1;
		srst_i = 1'b0;
		rd(OFS_LOADER_STATUS, 8'h00);
		rd(OFS_EVENT_FLAGS, 8'h00);
		rd(OFS_EVENT_ENABLES, 8'h00);
		rd(OFS_INPUT_LEVELS, 8'h00);
		rd(8'h86, 8'h00);
		ldr.present = 1'b1;
		ldr.loading = 1'b1;
		idle(1);
		rd(OFS_LOADER_STATUS, 8'h05);
		ldr.loading = 1'b0;
		ldr.ack_missing = 1'b1;
		idle(1);
		ldr.ack_missing = 1'b0;
		rd(OFS_LOADER_STATUS, 8'h06);
		acc(1'b1, 1'b1, 3'h1, OFS_LOADER_STATUS, 8'h02, 8'h00);
		wr(OFS_LOADER_STATUS, 8'hfd);
		rd(OFS_LOADER_STATUS, 8'h06);
		ldr.ack_missing = 1'b1;
		wr(OFS_LOADER_STATUS, 8'h02);
		ldr.ack_missing = 1'b0;
		rd(OFS_LOADER_STATUS, 8'h06);
		wr(OFS_LOADER_STATUS, 8'h02);
		rd(OFS_LOADER_STATUS, 8'h04);
		for (i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			wr(OFS_EVENT_ENABLES, v);
			rd(OFS_EVENT_ENABLES, v & EVENT_MASK);
		end
		wr(OFS_INPUT_LEVELS, 8'hff);
		rd(OFS_INPUT_LEVELS, 8'h00);
		sock.power_change = 1'b1;
		idle(1);
		sock.power_change = 1'b0;
		sock.hv_request_change = 1'b1;
		rd(OFS_EVENT_FLAGS, 8'h80);
		sock.hv_request_change = 1'b0;
		rd(OFS_EVENT_FLAGS, 8'hc0);
		wr(OFS_EVENT_FLAGS, 8'h40);
		rd(OFS_EVENT_FLAGS, 8'h80);
		sock.power_change = 1'b1;
		wr(OFS_EVENT_FLAGS, 8'hff);
		sock.power_change = 1'b0;
		rd(OFS_EVENT_FLAGS, 8'h80);
		wr(OFS_EVENT_FLAGS, 8'hff);
		route = 12'h001;
		pins[0] = 1'b1;
		idle(6);
		route = 12'h000;
		rd(OFS_EVENT_FLAGS, 8'h00);
		v = 8'($random(seed));
		pins = v[3:0];
		idle(6);
		rd(OFS_INPUT_LEVELS, {4'h0, v[3:0]});
		rd(OFS_EVENT_FLAGS, {4'h0, v[3:0] ^ 4'h1});
		wr(OFS_EVENT_FLAGS, 8'hff);
		route5 = ROUTE_GEN_EVENT;
		for (i = 0; i < 8; i++) if (i != 4 && i != 5) begin
			wr(OFS_EVENT_ENABLES, 8'h01 << i);
			if (i == 7)
				sock.power_change = 1'b1;
			else if (i == 6)
				sock.hv_request_change = 1'b1;
			else
				pins[i[1:0]] = ~pins[i[1:0]];
			idle(1);
			sock = '0;
			gpe_wait(1'b0);
			chk({7'h00, pin5}, 8'h00);
			idle(2);
			chk({7'h00, pin5_oe}, 8'h01);
			wr(OFS_EVENT_FLAGS, 8'hff);
			gpe_wait(1'b1);
			chk({7'h00, pin5}, 8'h01);
		end
		route5 = 3'h0;
		idle(2);
		chk({7'h00, pin5_oe}, 8'h00);
		chk(8'(expq.size()), 8'h00);
		results();
	end
endmodule
`default_nettype wire
